// file: rtl/ms_tick_if.sv
interface ms_tick_if;
    logic tick;
    modport src (output tick);
    modport snk (input tick);
endinterface

// file: rtl/ms_timebase.sv
module ms_timebase #(
    parameter int CYCLES_PER_MS = sweep_pkg::CYCLES_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    ms_tick_if.src ms
);
    logic [31:0] cnt;

    // one-cycle enable every millisecond
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 32'h0;
            ms.tick <= 1'b0;
        end else if (cnt == 32'(CYCLES_PER_MS - 1)) begin
            cnt <= 32'h0;
            ms.tick <= 1'b1;
        end else begin
            cnt <= cnt + 32'h1;
            ms.tick <= 1'b0;
        end
    end

endmodule

// file: rtl/plc_sweep_scheduler.sv
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
module plc_sweep_scheduler #(
    parameter int CYCLES_PER_MS = sweep_pkg::CYCLES_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] phase,
    input wire logic phase_done,
    input wire logic cc_pending,
    input wire logic bp_pending,
    output logic cc_open,
    output logic bp_open,
    output logic bg_open,
    output logic window_close,
    output logic logic_start,
    output logic clear_nonret,
    output logic oversweep_flag,
    output logic oversweep_fault
);
    // ---------------------------------------------------------------
    // registers and state
    // ---------------------------------------------------------------
    logic [8:0] ctrl;
    logic [11:0] csweep;
    logic [7:0] cwin;
    logic [7:0] cc_time;
    logic [7:0] bp_time;
    logic [7:0] bg_time;
    logic [11:0] last_sweep;
    logic [15:0] fault_cnt;
    logic [11:0] sweep_ms;
    logic [11:0] win_ms;
    logic [11:0] cw_ms;
    logic [31:0] sweep_sub;
    logic [31:0] cw_sub;
    logic sweep_tick;
    logic cw_tick;
    logic run_q;
    sweep_pkg::phase_t state;
    sweep_pkg::phase_t next_state;
    ms_tick_if ms ();

    ms_timebase #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timebase (
        .aclk(aclk),
        .aresetn(aresetn),
        .ms(ms)
    );

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    logic [1:0] sw_mode;
    logic [1:0] cc_mode;
    logic [1:0] bp_mode;
    logic run;
    logic cw_on;
    logic cs_on;
    logic alt_end;
    logic ovr_now;
    logic sweep_start;
    logic win_done;
    logic w_pend;
    logic [1:0] w_mode;
    logic [7:0] w_limit;

    assign sw_mode = ctrl[sweep_pkg::CTRL_SWEEP_LSB +: 2];
    assign cc_mode = ctrl[sweep_pkg::CTRL_CC_LSB +: 2];
    assign bp_mode = ctrl[sweep_pkg::CTRL_BP_LSB +: 2];
    assign run = ctrl[sweep_pkg::CTRL_RUN_BIT];
    // one window in constant mode drags the others along
    assign cw_on = sw_mode == sweep_pkg::SWEEP_CWIN
        || cc_mode == sweep_pkg::WIN_CONST
        || bp_mode == sweep_pkg::WIN_CONST
        || ctrl[sweep_pkg::CTRL_BG_BIT];
    // an unloaded period keeps the scheduler in normal sweep
    assign cs_on = !cw_on && sw_mode == sweep_pkg::SWEEP_CONST
        && csweep != 12'h0;
    assign alt_end = cs_on ? (sweep_ms >= csweep)
                           : (cw_ms >= {4'h0, cwin});
    assign ovr_now = cs_on && sweep_ms > csweep;

    always_comb begin
        case (state)
            sweep_pkg::PH_CC: begin
                w_pend = cc_pending;
                w_mode = cc_mode;
                w_limit = cc_time;
            end
            sweep_pkg::PH_BP: begin
                w_pend = bp_pending;
                w_mode = bp_mode;
                w_limit = bp_time;
            end
            default: begin
                w_pend = 1'b0;
                w_mode = sweep_pkg::WIN_LIMITED;
                w_limit = bg_time;
            end
        endcase
        if (state == sweep_pkg::PH_BG)
            win_done = win_ms >= {4'h0, w_limit};
        else if (w_mode == sweep_pkg::WIN_LIMITED)
            win_done = !w_pend
                || win_ms >= {4'h0, w_limit};
        else
            win_done = !w_pend;
    end

    // ---------------------------------------------------------------
    // sweep sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            sweep_pkg::PH_HK: begin
                if (phase_done)
                    next_state = sweep_pkg::PH_IN;
            end
            sweep_pkg::PH_IN: begin
                if (phase_done)
                    next_state = run ? sweep_pkg::PH_LOGIC
                                     : sweep_pkg::PH_OUT;
            end
            sweep_pkg::PH_LOGIC: begin
                if (phase_done)
                    next_state = sweep_pkg::PH_OUT;
            end
            sweep_pkg::PH_OUT: begin
                // an overrun leaves no time for any window
                if (phase_done)
                    next_state = (cs_on && sweep_ms >= csweep)
                        ? sweep_pkg::PH_HK : sweep_pkg::PH_CC;
            end
            sweep_pkg::PH_CC, sweep_pkg::PH_BP, sweep_pkg::PH_BG: begin
                if (cs_on || cw_on) begin
                    // rotate on idle or each millisecond, polling requests
                    if (alt_end)
                        next_state = sweep_pkg::PH_HK;
                    else if (!w_pend || ms.tick)
                        next_state = state == sweep_pkg::PH_BG
                            ? sweep_pkg::PH_CC
                            : sweep_pkg::phase_t'(state + 3'h1);
                end else if (win_done) begin
                    next_state = state == sweep_pkg::PH_BG
                        ? sweep_pkg::PH_HK
                        : sweep_pkg::phase_t'(state + 3'h1);
                end
            end
            default: next_state = sweep_pkg::PH_HK;
        endcase
    end

    assign sweep_start = state != sweep_pkg::PH_HK
        && next_state == sweep_pkg::PH_HK;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            state <= sweep_pkg::PH_HK;
        else
            state <= next_state;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            window_close <= 1'b0;
            logic_start <= 1'b0;
        end else begin
            window_close <= sweep_start && state[2];
            logic_start <= state == sweep_pkg::PH_IN
                && next_state == sweep_pkg::PH_LOGIC;
        end
    end

    assign phase = state;
    assign cc_open = state == sweep_pkg::PH_CC;
    assign bp_open = state == sweep_pkg::PH_BP;
    assign bg_open = state == sweep_pkg::PH_BG;

    // ---------------------------------------------------------------
    // millisecond timers
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            sweep_ms <= 12'h0;
        else if (sweep_start)
            sweep_ms <= 12'h0;
        else if (sweep_tick && sweep_ms != 12'hfff)
            sweep_ms <= sweep_ms + 12'h1;
    end

    // sweep and constant window keep their own sub-millisecond counts from
    // their start, so a partial millisecond never cuts either short
    assign sweep_tick = sweep_sub == 32'(CYCLES_PER_MS - 1);
    assign cw_tick = cw_sub == 32'(CYCLES_PER_MS - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn || sweep_start)
            sweep_sub <= 32'h1;
        else if (sweep_tick)
            sweep_sub <= 32'h0;
        else
            sweep_sub <= sweep_sub + 32'h1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state == sweep_pkg::PH_OUT)
            cw_sub <= 32'h1;
        else if (cw_tick)
            cw_sub <= 32'h0;
        else
            cw_sub <= cw_sub + 32'h1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            win_ms <= 12'h0;
        else if (next_state != state)
            win_ms <= 12'h0;
        else if (ms.tick && win_ms != 12'hfff)
            win_ms <= win_ms + 12'h1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            cw_ms <= 12'h0;
        else if (state == sweep_pkg::PH_OUT)
            cw_ms <= 12'h0;
        else if (cw_tick && cw_ms != 12'hfff)
            cw_ms <= cw_ms + 12'h1;
    end

    // ---------------------------------------------------------------
    // oversweep and run transitions
    // ---------------------------------------------------------------
    logic st_write;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] wd;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oversweep_flag <= 1'b0;
            oversweep_fault <= 1'b0;
            fault_cnt <= 16'h0;
            last_sweep <= 12'h0;
        end else begin
            oversweep_fault <= sweep_start && ovr_now;
            // a new overrun beats a software clear in the same cycle
            if (sweep_start && ovr_now) begin
                oversweep_flag <= 1'b1;
                fault_cnt <= fault_cnt + 16'h1;
            end else if (st_write && wd[0]) begin
                oversweep_flag <= 1'b0;
            end
            if (sweep_start)
                last_sweep <= sweep_ms;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            clear_nonret <= 1'b0;
        end else begin
            run_q <= run;
            clear_nonret <= run && !run_q;
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite write channel
    // ---------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic wr_ok;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = (aw_held || s_axi_awvalid)
        && (w_held || s_axi_wvalid) && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h0;
            wr_data <= 32'h0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
            end
        end
    end

    logic [7:0] wa;
    logic [3:0] ws;
    logic [3:0] ws_q;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            ws_q <= 4'h0;
        else if (s_axi_wvalid && s_axi_wready)
            ws_q <= s_axi_wstrb;
    end

    assign wa = aw_held ? wr_addr : s_axi_awaddr;
    assign wd = w_held ? wr_data : s_axi_wdata;
    assign ws = w_held ? ws_q : s_axi_wstrb;
    // only the two low lanes carry data; partial writes are dropped
    assign wr_ok = wr_fire && ws[1:0] == 2'b11;
    assign st_write = wr_ok && wa == sweep_pkg::ADDR_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sweep_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wa > sweep_pkg::ADDR_FAULTS || wa[1:0] != 2'b00
                ? sweep_pkg::RESP_SLVERR : sweep_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // registers hold their values while stopped, so reads stay as left
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= sweep_pkg::CTRL_RST;
            csweep <= sweep_pkg::CSWEEP_RST;
            cwin <= sweep_pkg::CWIN_RST;
            cc_time <= sweep_pkg::CC_TIME_RST;
            bp_time <= sweep_pkg::BP_TIME_RST;
            bg_time <= sweep_pkg::BG_TIME_RST;
        end else if (wr_ok) begin
            case (wa)
                sweep_pkg::ADDR_CTRL: ctrl <= wd[8:0];
                sweep_pkg::ADDR_CSWEEP: begin
                    if (wd[31:12] == 20'h0 && wd[11:0] >= sweep_pkg::CSWEEP_MIN
                        && wd[11:0] <= sweep_pkg::CSWEEP_MAX)
                        csweep <= wd[11:0];
                end
                sweep_pkg::ADDR_CWIN: begin
                    if (wd[31:8] == 24'h0 && wd[7:0] >= sweep_pkg::CWIN_MIN)
                        cwin <= wd[7:0];
                end
                sweep_pkg::ADDR_CC_TIME: cc_time <= wd[7:0];
                sweep_pkg::ADDR_BP_TIME: bp_time <= wd[7:0];
                sweep_pkg::ADDR_BG_TIME: bg_time <= wd[7:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite read channel
    // ---------------------------------------------------------------
    logic [31:0] rd_mux;
    logic rd_err;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_mux = 32'h0;
        rd_err = 1'b0;
        case (s_axi_araddr)
            sweep_pkg::ADDR_CTRL: rd_mux = {23'h0, ctrl};
            sweep_pkg::ADDR_CSWEEP: rd_mux = {20'h0, csweep};
            sweep_pkg::ADDR_CWIN: rd_mux = {24'h0, cwin};
            sweep_pkg::ADDR_CC_TIME: rd_mux = {24'h0, cc_time};
            sweep_pkg::ADDR_BP_TIME: rd_mux = {24'h0, bp_time};
            sweep_pkg::ADDR_BG_TIME: rd_mux = {24'h0, bg_time};
            sweep_pkg::ADDR_STATUS: begin
                rd_mux[0] = oversweep_flag;
                rd_mux[sweep_pkg::STAT_PHASE_LSB +: 3] = state;
                rd_mux[sweep_pkg::STAT_CS_BIT] = cs_on;
                rd_mux[sweep_pkg::STAT_CW_BIT] = cw_on;
            end
            sweep_pkg::ADDR_LAST_SWEEP: rd_mux = {20'h0, last_sweep};
            sweep_pkg::ADDR_FAULTS: rd_mux = {16'h0, fault_cnt};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= sweep_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_err ? sweep_pkg::RESP_SLVERR
                                  : sweep_pkg::RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_sweep_period: assert property (
        (sweep_start && cs_on && !ovr_now) |-> sweep_ms == csweep)
        else $error("constant sweep started off period");
    a_cs_range: assert property (
        csweep == 12'h0 || (csweep >= sweep_pkg::CSWEEP_MIN
        && csweep <= sweep_pkg::CSWEEP_MAX))
        else $error("constant sweep period out of range");
    a_cw_range: assert property (
        cwin >= sweep_pkg::CWIN_MIN)
        else $error("constant window time out of range");
    a_ovs_set: assert property (
        (sweep_start && ovr_now) |=> oversweep_flag && oversweep_fault)
        else $error("oversweep not flagged");
    a_sweep_restart: assert property (
        sweep_start |=> sweep_ms == 12'h0 ##1 sweep_ms <= 12'h1)
        else $error("sweep timer not restarted");
    a_cw_expiry: assert property (
        (cw_on && state[2] && alt_end)
        |=> state == sweep_pkg::PH_HK && window_close)
        else $error("constant window did not close");
    a_limit_idle: assert property (
        (cc_open && !cs_on && !cw_on && cc_mode == sweep_pkg::WIN_LIMITED
        && !cc_pending) |=> !cc_open)
        else $error("idle limited window stayed open");
    a_rtc_hold: assert property (
        (cc_open && !cs_on && !cw_on && cc_mode == sweep_pkg::WIN_RTC
        && cc_pending) |=> cc_open)
        else $error("completion window left with work pending");
    a_all_const: assert property (
        (bp_mode == sweep_pkg::WIN_CONST) |-> cw_on && !cs_on)
        else $error("constant mode not forced on all windows");
    a_run_clear: assert property (
        $rose(run) |=> clear_nonret ##1 !clear_nonret)
        else $error("non-retentive clear not pulsed");

    c_cs_sweep: cover property (sweep_start && cs_on);
    c_overrun: cover property (sweep_start && ovr_now);
    c_cw_close: cover property (cw_on && window_close);
    c_limit_cut: cover property (cc_open && win_done && cc_pending);

endmodule

// file: rtl/sweep_pkg.sv
package sweep_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CSWEEP = 8'h04;
    localparam logic [7:0] ADDR_CWIN = 8'h08;
    localparam logic [7:0] ADDR_CC_TIME = 8'h0c;
    localparam logic [7:0] ADDR_BP_TIME = 8'h10;
    localparam logic [7:0] ADDR_BG_TIME = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_LAST_SWEEP = 8'h1c;
    localparam logic [7:0] ADDR_FAULTS = 8'h20;

    // ---------------------------------------------------------------
    // control and status fields
    // ---------------------------------------------------------------
    localparam int CTRL_SWEEP_LSB = 0;
    localparam int CTRL_CC_LSB = 2;
    localparam int CTRL_BP_LSB = 4;
    localparam int CTRL_BG_BIT = 6;
    localparam int CTRL_RUN_BIT = 8;
    localparam int CTRL_W = 9;
    localparam int STAT_PHASE_LSB = 4;
    localparam int STAT_CS_BIT = 8;
    localparam int STAT_CW_BIT = 9;

    // ---------------------------------------------------------------
    // values after reset and legal ranges
    // ---------------------------------------------------------------
    localparam logic [8:0] CTRL_RST = 9'h004;
    localparam logic [11:0] CSWEEP_RST = 12'h000;
    localparam logic [7:0] CWIN_RST = 8'h03;
    localparam logic [7:0] CC_TIME_RST = 8'h0a;
    localparam logic [7:0] BP_TIME_RST = 8'hff;
    localparam logic [7:0] BG_TIME_RST = 8'h00;
    localparam logic [11:0] CSWEEP_MIN = 12'h005;
    localparam logic [11:0] CSWEEP_MAX = 12'h9f6;
    localparam logic [7:0] CWIN_MIN = 8'h03;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SWEEP_NORMAL = 2'b00,
        SWEEP_CONST = 2'b01,
        SWEEP_CWIN = 2'b10
    } sweep_mode_t;

    typedef enum logic [1:0] {
        WIN_RTC = 2'b00,
        WIN_LIMITED = 2'b01,
        WIN_CONST = 2'b10
    } win_mode_t;

    typedef enum logic [2:0] {
        PH_HK = 3'b000,
        PH_IN = 3'b001,
        PH_LOGIC = 3'b010,
        PH_OUT = 3'b011,
        PH_CC = 3'b100,
        PH_BP = 3'b101,
        PH_BG = 3'b110
    } phase_t;

endpackage

// file: sim/far_side.sv
module far_side (
    input wire logic aclk,
    input wire logic [2:0] phase,
    input wire logic stall,
    input wire logic [1:0] req,
    output logic phase_done,
    output logic cc_pending,
    output logic bp_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cnt = 1'b0;
    initial begin
        phase_done = 1'b0;
        cc_pending = 1'b0;
        bp_pending = 1'b0;
    end
    // stall only holds the logic phase, so an overrun comes from logic time
    always @(posedge aclk) begin
        cnt <= !cnt;
        phase_done <= phase < 3'h4 && cnt && !(stall && phase == 3'h2);
        cc_pending <= req[0];
        bp_pending <= req[1];
    end
endmodule

// file: sim/plc_sweep_scheduler_bench.sv
module plc_sweep_scheduler_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CPM = 10;
    logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, phase_done, cc_pending;
    logic bp_pending, logic_start, clear_nonret, oversweep_flag;
    logic cc_open, bp_open, bg_open, window_close, oversweep_fault;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, req = 2'b00;
    logic [2:0] phase, pp = 3'h0;
    int seed = 32'h6d5be50c, fail_count = 0, comparisons = 0, sweeps = 0;
    int starts = 0, clears = 0, now = 0, last = 0, gap = 0, s0;
    int closes = 0, faults = 0, wcnt = 0, wl = 0;
    logic [2:0] oh;
    int ta[8] = '{4, 4, 4, 4, 8, 8, 8, 8};
    int tv[8] = '{4, 2551, 2550, 5, 2, 256, 255, 3};
    int te[8] = '{0, 0, 2550, 5, 3, 3, 255, 3};
    int ra[5] = '{0, 8, 12, 16, 20}, re[5] = '{4, 3, 10, 255, 0};
    plc_sweep_scheduler #(.CYCLES_PER_MS(CPM)) i_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .phase, .phase_done, .cc_pending, .bp_pending,
        .cc_open, .bp_open, .bg_open, .window_close, .logic_start,
        .clear_nonret, .oversweep_flag, .oversweep_fault);
    far_side i_far (.aclk, .phase, .stall, .req, .phase_done, .cc_pending,
        .bp_pending);
    initial forever #2.5 aclk = ~aclk;
    always @(posedge aclk) req <= 2'($random(seed));
    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(negedge aclk) begin
        now++;
        if (phase >= 3'h4)
            wcnt++;
        if (aresetn && phase !== pp) begin
            if (phase == 3'h1 || phase == 3'h2)
                check("order", pp, phase - 1);
            oh = {phase == 3'h4, phase == 3'h5, phase == 3'h6};
            check("open", {cc_open, bp_open, bg_open}, oh);
            if (phase == 3'h0) begin
                gap = now - last;
                last = now;
                wl = wcnt;
                wcnt = 0;
                sweeps++;
            end
        end
        pp = phase;
        starts += int'(logic_start);
        clears += int'(clear_nonret);
        closes += int'(window_close);
        faults += int'(oversweep_fault);
    end
    task automatic wr(input int a, input logic [31:0] v);
        logic ga, gw, gb;
        s_axi_awaddr <= 8'(a);
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ga = s_axi_awready;
            gw = s_axi_wready;
            gb = s_axi_bvalid;
            @(posedge aclk);
            if (ga) s_axi_awvalid <= 1'b0;
            if (gw) s_axi_wvalid <= 1'b0;
        end while (!gb);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input int a);
        logic ga, gr;
        s_axi_araddr <= 8'(a);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ga = s_axi_arready;
            gr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ga) s_axi_arvalid <= 1'b0;
        end while (!gr);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic sweep_wait(input int n);
        s0 = sweeps + n;
        while (sweeps < s0) @(posedge aclk);
    endtask
    task tally_and_finish;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i]);
            check("reset value", d, re[i]);
        end
        s_axi_wstrb <= 4'h1;
        wr(20, 7);
        s_axi_wstrb <= 4'hf;
        rd(20);
        check("partial write", d, 0);
        rd(36);
        check("unmapped", r, 2'b10);
        for (int i = 0; i < 8; i++) begin
            wr(ta[i], tv[i]);
            rd(ta[i]);
            check("timer range", d, te[i]);
        end
        wr(12, $random(seed) & 3);
        s0 = clears;
        wr(0, 32'h104);
        repeat (3) @(posedge aclk);
        check("clear pulse", clears - s0, 1);
        sweep_wait(1);
        starts = 0;
        closes = 0;
        sweep_wait(4);
        check("logic once", starts, 4);
        check("window close", closes, 4);
        wr(0, 32'h105); // period loaded first
        sweep_wait(3);
        check("period", gap, 5 * CPM);
        check("no overrun", oversweep_flag, 0);
        stall <= 1'b1;
        repeat (8 * CPM) @(posedge aclk);
        stall <= 1'b0;
        sweep_wait(2);
        check("overrun", oversweep_flag, 1);
        check("fault pulse", faults, 1);
        check("next full", gap, 5 * CPM);
        rd(32);
        check("fault count", d, 1);
        wr(0, 32'h106);
        wr(24, 1);
        rd(24);
        check("flag clear", d[0], 0);
        sweep_wait(3);
        check("window time", wl, 3 * CPM);
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        tally_and_finish;
    end
endmodule
